// >>> hdl/hjprc_top.sv
// shared serial/test port mux, reset handling and lock-select control
// How it works
// - mode pin high gives the four serial pins to test; low to host.
// - all bits shift in step with the shared serial/test clock.
// - host mode samples address and data on serial-in at clock rise.
// - test mode uses serial-in as test data input.
// - host mode drives register contents on serial-out with the clock.
// - test mode uses serial-out as test data output.
// - host select is active low; activity ignored while it is high.
// - test mode uses the select pin as active-high test mode select.
// - reset low in host mode forces registers and blocks to defaults.
// - host reset floats all signal pins; video clocks a and b low.
// - reset release in host mode resumes from defaults.
// - reset low in test mode: defaults and test controller held.
// - reset release in test mode lets the test controller run.
// - lock-select low: enter locked mode only after lock achieved.
// - lock-select high: video clock and timing free-run.
// - audio clocks follow the output video clock regardless of pin.
// - lock without reference: outputs follow internal defaults.
`timescale 1ns/10ps
`include "hjprc_params.svh"
module hjprc_top
#(
	parameter int PWRUP_HOLD_CYC = `HJPRC_PWRUP_HOLD_CYC
)
(
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    port_mode_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    shared_serial_clock_i,
	input  wire logic                    shared_serial_in_i,
	input  wire logic                    shared_select_i,
	output logic                         shared_serial_out_o,
	output logic                         shared_serial_out_oe_o,
	input  wire logic                    lock_select_n_i,
	input  wire logic                    ref_present_i,
	input  wire logic                    lock_achieved_i,
	output hjprc_pkg::hjprc_lock_e       lock_state_o,
	output logic                         audio_follow_video_o,
	output logic                         func_reset_o,
	output logic                         signal_pins_oe_o,
	output logic                         video_clk_force_low_o,
	output logic                         cfg_we_o,
	output hjprc_pkg::hjprc_word_t       cfg_wdata_o,
	output logic [`HJPRC_ADDR_BITS-1:0]  cfg_addr_o,
	input  wire hjprc_pkg::hjprc_word_t  cfg_rdata_i
);
	import hjprc_pkg::*;

	localparam int BITS = `HJPRC_DATA_BITS;

	if (PWRUP_HOLD_CYC < 1)
	begin : g_hold_chk
		$error("hjprc_top: PWRUP_HOLD_CYC must be at least 1");
	end

	function automatic logic rise(input logic now, input logic prev);
		rise = now && !prev;
	endfunction : rise

	// the six mode, reset, serial and lock-select pins pass two flops first; ref and lock-achieved inputs do not
	logic [5:0] pins_s;
	hjprc_sync #(.WIDTH(6)) u_sync
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.async_i   ({port_mode_i, reset_n_i, shared_serial_clock_i,
		              shared_serial_in_i, shared_select_i,
		              lock_select_n_i}),
		.sync_o    (pins_s)
	);

	logic test_mode_s;
	logic rstn_s;
	logic sck_s;
	logic sdi_s;
	logic sel_s;
	logic lksel_n_s;
	assign {test_mode_s, rstn_s, sck_s, sdi_s, sel_s, lksel_n_s} = pins_s;

	logic sck_d_r;
	logic sck_rise;
	logic sck_fall;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sck_s;
	end

	assign sck_rise = rise(sck_s, sck_d_r);
	assign sck_fall = rise(sck_d_r, sck_s);

	// reset follows the synchronised pin level; release takes effect at once, with no count
	logic in_reset;
	assign in_reset = !rstn_s;
	assign func_reset_o = in_reset;

	// host mode reset floats signal pins, video clocks held low
	assign signal_pins_oe_o      = !(in_reset && !test_mode_s);
	assign video_clk_force_low_o = in_reset && !test_mode_s;

	// host serial port: rd/wr bit, address, data, msb first
	typedef enum logic [1:0]
	{
		HS_IDLE,
		HS_CMD,
		HS_DATA
	} hjprc_hs_e;

	hjprc_hs_e            hs_r;
	logic [4:0]           bitcnt_r;
	logic [BITS-1:0]      cmd_r;
	logic [BITS-1:0]      shin_r;
	logic [BITS-1:0]      shout_r;
	logic                 host_act;
	logic                 sdo_r;
	logic                 sdo_en_r;

	// chip select active low; host logic inactive in test mode
	assign host_act = !test_mode_s && !sel_s && !in_reset;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || !host_act)
		begin
			hs_r     <= HS_IDLE;
			bitcnt_r <= 5'h00;
			cmd_r    <= '0;
			shin_r   <= '0;
		end
		else if (sck_rise)
		begin
			case (hs_r)
				HS_IDLE, HS_CMD:
				begin
					cmd_r <= {cmd_r[BITS-2:0], sdi_s};
					if (bitcnt_r == 5'(BITS - 1))
					begin
						hs_r     <= HS_DATA;
						bitcnt_r <= 5'h00;
					end
					else
					begin
						hs_r     <= HS_CMD;
						bitcnt_r <= bitcnt_r + 5'h01;
					end
				end
				HS_DATA:
				begin
					shin_r <= {shin_r[BITS-2:0], sdi_s};
					if (bitcnt_r == 5'(BITS - 1))
						bitcnt_r <= 5'h00;
					else
						bitcnt_r <= bitcnt_r + 5'h01;
				end
				default: hs_r <= HS_IDLE;
			endcase
		end
	end

	// write strobe once the data word is complete
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || !host_act)
		begin
			cfg_we_o    <= 1'b0;
			cfg_wdata_o <= `HJPRC_DEF_CFG;
		end
		else
		begin
			cfg_we_o <= 1'b0;
			if (sck_rise && hs_r == HS_DATA && bitcnt_r == 5'(BITS - 1)
				&& !cmd_r[`HJPRC_RDWR_BIT])
			begin
				cfg_we_o    <= 1'b1;
				cfg_wdata_o <= {shin_r[BITS-2:0], sdi_s};
			end
		end
	end

	assign cfg_addr_o = cmd_r[`HJPRC_ADDR_BITS-1:0];

	// read data loaded after the command word, shifted on falling edge
	logic load_rd;
	logic load_rd_r;
	assign load_rd = sck_rise && hs_r != HS_DATA
		&& bitcnt_r == 5'(BITS - 1);

	// taken a cycle late: the address holds its last bit only then
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || !host_act)
		begin
			load_rd_r <= 1'b0;
			shout_r   <= '0;
			sdo_r     <= 1'b0;
			sdo_en_r  <= 1'b0;
		end
		else
		begin
			load_rd_r <= load_rd;
			if (load_rd_r)
				shout_r <= cfg_rdata_i;
			else if (sck_fall && hs_r == HS_DATA
				&& cmd_r[`HJPRC_RDWR_BIT])
			begin
				sdo_en_r <= 1'b1;
				sdo_r    <= shout_r[BITS-1];
				shout_r  <= {shout_r[BITS-2:0], 1'b0};
			end
		end
	end

	// test port shares the same pins
	logic tdo;
	logic tdo_en;
	logic tap_rst;
	hjprc_tap u_tap
	(
		.sys_clk_i  (sys_clk_i),
		.rst_i      (rst_i),
		.hold_rst_i (in_reset || !test_mode_s),
		.tck_rise_i (sck_rise),
		.tck_fall_i (sck_fall),
		.tms_i      (sel_s),
		.tdi_i      (sdi_s),
		.tdo_o      (tdo),
		.tdo_en_o   (tdo_en),
		.in_reset_o (tap_rst)
	);

	// output mux on mode; floats in host reset
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			shared_serial_out_o    <= 1'b0;
			shared_serial_out_oe_o <= 1'b0;
		end
		else if (test_mode_s)
		begin
			shared_serial_out_o    <= tdo;
			shared_serial_out_oe_o <= tdo_en;
		end
		else
		begin
			shared_serial_out_o    <= sdo_r;
			shared_serial_out_oe_o <= sdo_en_r && !in_reset;
		end
	end

	// lock selection
	hjprc_lock_e lk_r;
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || in_reset)
			lk_r <= HJPRC_LK_FREE;
		else if (lksel_n_s)
			lk_r <= HJPRC_LK_FREE;
		else
		begin
			case (lk_r)
				HJPRC_LK_FREE, HJPRC_LK_DEFAULT:
					lk_r <= ref_present_i ? HJPRC_LK_ACQUIRE
						: HJPRC_LK_DEFAULT;
				HJPRC_LK_ACQUIRE:
					if (!ref_present_i)
						lk_r <= HJPRC_LK_DEFAULT;
					else if (lock_achieved_i)
						lk_r <= HJPRC_LK_LOCKED;
				HJPRC_LK_LOCKED:
					if (!ref_present_i)
						lk_r <= HJPRC_LK_DEFAULT;
					else if (!lock_achieved_i)
						lk_r <= HJPRC_LK_ACQUIRE;
				default: lk_r <= HJPRC_LK_FREE;
			endcase
		end
	end

	assign lock_state_o         = lk_r;
	assign audio_follow_video_o = 1'b1;

	// checks
	sequence cmd_done_s;
		sck_rise && host_act && hs_r != HS_DATA
			&& bitcnt_r == 5'(BITS - 1);
	endsequence

	lock_needs_ach_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		$rose(lk_r == HJPRC_LK_LOCKED) |-> $past(lock_achieved_i))
		else $error("locked without lock achieved");
	free_run_sel_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		lksel_n_s |=> lk_r == HJPRC_LK_FREE)
		else $error("not free-running with lock-select high");
	no_ref_def_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		!in_reset && !lksel_n_s && !ref_present_i
		&& lk_r != HJPRC_LK_FREE |=> lk_r == HJPRC_LK_DEFAULT)
		else $error("no reference but not default");
	host_rst_pins_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		in_reset && !test_mode_s |-> !signal_pins_oe_o
		&& video_clk_force_low_o)
		else $error("host reset pin state wrong");
	sel_high_idle_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		sel_s |=> hs_r == HS_IDLE && !cfg_we_o)
		else $error("serial activity with select high");
	cmd_to_data_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		cmd_done_s |=> hs_r == HS_DATA && bitcnt_r == 5'h00)
		else $error("command word did not finish");
	tap_held_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		in_reset && test_mode_s |=> tap_rst)
		else $error("test controller not held");
	test_out_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		test_mode_s |=> shared_serial_out_o == $past(tdo))
		else $error("serial out not test data");
	audio_lock_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		audio_follow_video_o)
		else $error("audio not following video clock");

endmodule : hjprc_top

// >>> shared/hjprc_params.svh
// timing counts and reset values for the port, reset and lock control block
`ifndef HJPRC_PARAMS_SVH
`define HJPRC_PARAMS_SVH

`define HJPRC_CLK_HZ          50000000
`define HJPRC_PWRUP_HOLD_US   500
`define HJPRC_PWRUP_HOLD_CYC  ((`HJPRC_CLK_HZ / 1000000) * `HJPRC_PWRUP_HOLD_US)
`define HJPRC_ADDR_BITS       8
`define HJPRC_DATA_BITS       16
`define HJPRC_RDWR_BIT        15
`define HJPRC_DEF_CFG         16'h0000

`endif

// >>> shared/hjprc_pkg.sv
// types shared by the port, reset and lock control block
package hjprc_pkg;

	typedef enum logic [1:0]
	{
		HJPRC_PORT_HOST,
		HJPRC_PORT_TEST
	} hjprc_port_e;

	typedef enum logic [1:0]
	{
		HJPRC_LK_FREE,
		HJPRC_LK_DEFAULT,
		HJPRC_LK_ACQUIRE,
		HJPRC_LK_LOCKED
	} hjprc_lock_e;

	typedef logic [15:0] hjprc_word_t;

endpackage : hjprc_pkg

// >>> hdl/hjprc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module hjprc_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1)
	begin : g_width_chk
		$error("hjprc_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			meta_r <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule : hjprc_sync

// >>> hdl/hjprc_tap.sv
// boundary-scan test controller with bypass data path
`timescale 1ns/10ps
module hjprc_tap
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic hold_rst_i,
	input  wire logic tck_rise_i,
	input  wire logic tck_fall_i,
	input  wire logic tms_i,
	input  wire logic tdi_i,
	output logic      tdo_o,
	output logic      tdo_en_o,
	output logic      in_reset_o
);
	typedef enum logic [3:0]
	{
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} hjprc_tap_e;

	hjprc_tap_e st_r;
	hjprc_tap_e st_nxt;
	logic       byp_r;
	logic       ir_r;

	always_comb
	begin
		case (st_r)
			TLR:     st_nxt = tms_i ? TLR : RTI;
			RTI:     st_nxt = tms_i ? SEL_DR : RTI;
			SEL_DR:  st_nxt = tms_i ? SEL_IR : CAP_DR;
			CAP_DR:  st_nxt = tms_i ? EX1_DR : SH_DR;
			SH_DR:   st_nxt = tms_i ? EX1_DR : SH_DR;
			EX1_DR:  st_nxt = tms_i ? UPD_DR : PA_DR;
			PA_DR:   st_nxt = tms_i ? EX2_DR : PA_DR;
			EX2_DR:  st_nxt = tms_i ? UPD_DR : SH_DR;
			UPD_DR:  st_nxt = tms_i ? SEL_DR : RTI;
			SEL_IR:  st_nxt = tms_i ? TLR : CAP_IR;
			CAP_IR:  st_nxt = tms_i ? EX1_IR : SH_IR;
			SH_IR:   st_nxt = tms_i ? EX1_IR : SH_IR;
			EX1_IR:  st_nxt = tms_i ? UPD_IR : PA_IR;
			PA_IR:   st_nxt = tms_i ? EX2_IR : PA_IR;
			EX2_IR:  st_nxt = tms_i ? UPD_IR : SH_IR;
			UPD_IR:  st_nxt = tms_i ? SEL_DR : RTI;
			default: st_nxt = TLR;
		endcase
	end

	// controller held in its reset state while the reset pin is low
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || hold_rst_i)
			st_r <= TLR;
		else if (tck_rise_i)
			st_r <= st_nxt;
	end

	// one-bit bypass and one-bit instruction registers: no scan cells beyond this block
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || hold_rst_i)
		begin
			byp_r <= 1'b0;
			ir_r  <= 1'b1;
		end
		else if (tck_rise_i)
		begin
			if (st_r == SH_DR)
				byp_r <= tdi_i;
			else if (st_r == CAP_DR)
				byp_r <= 1'b0;
			if (st_r == SH_IR)
				ir_r <= tdi_i;
			else if (st_r == CAP_IR)
				ir_r <= 1'b1;
		end
	end

	// tdo changes on the falling test clock edge
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || hold_rst_i)
		begin
			tdo_o    <= 1'b0;
			tdo_en_o <= 1'b0;
		end
		else if (tck_fall_i)
		begin
			tdo_en_o <= (st_r == SH_DR) || (st_r == SH_IR);
			tdo_o    <= (st_r == SH_IR) ? ir_r : byp_r;
		end
	end

	assign in_reset_o = (st_r == TLR);

endmodule : hjprc_tap

// >>> test/hjprc_host_model.sv
// host controller and boundary-scan tester on the shared serial pins
`timescale 1ns/10ps
module hjprc_host_model
(
	input  wire logic sys_clk_i,
	input  wire logic shared_serial_out_i,
	input  wire logic shared_serial_out_oe_i,
	output logic      sclk_o,
	output logic      sel_o,
	output logic      sdi_o
);
	// serial clock stands low outside frames
	initial
	begin
		sclk_o = 1'b0;
		sel_o  = 1'b1;
		sdi_o  = 1'b0;
	end

	// half of the 160 ns serial clock period
	task automatic half;
		repeat (4) @(negedge sys_clk_i);
	endtask : half

	// command word then data word, msb first
	task automatic frame(input logic [15:0] cmd, input logic [15:0] dat,
		input logic sel_v, output logic [15:0] rd, output logic oe);
		logic [31:0] w;
		w = {cmd, dat};
		rd = 16'h0000;
		oe = 1'b0;
		sel_o = sel_v;
		half;
		for (int i = 0; i < 32; i++)
		begin
			sdi_o = w[31-i];
			half;
			sclk_o = 1'b1;
			half;
			// sampled late in the high phase, after the device's fall update
			if (i >= 16)
				rd[31-i] = shared_serial_out_i;
			if (i == 16)
				oe = shared_serial_out_oe_i;
			sclk_o = 1'b0;
		end
		half;
		sel_o = 1'b1;
		// released data line shows the inverse, not the last bit
		sdi_o = ~sdi_o;
		// select must be seen high between frames, or words run on
		half;
	endtask : frame

	// one test clock with given mode select and data in
	task automatic tck(input logic tms, input logic tdi,
		output logic tdo, output logic oe);
		sel_o = tms;
		sdi_o = tdi;
		half;
		sclk_o = 1'b1;
		half;
		sclk_o = 1'b0;
		half;
		tdo = shared_serial_out_i;
		oe = shared_serial_out_oe_i;
	endtask : tck
endmodule : hjprc_host_model

// >>> test/tb.sv
// self-checking bench for the port, reset and lock control block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
	end end
module tb;
	import hjprc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        pmode = 1'b0;
	logic        rst_n = 1'b0;
	logic        lsel_n = 1'b1;
	logic        ref_p = 1'b0;
	logic        ach = 1'b0;
	hjprc_word_t rdata = 16'h0000;
	logic        sclk, sel, sdi, sdo, sdo_oe, aud, fres, poe, vlow, we;
	hjprc_lock_e lst;
	hjprc_word_t wdata;
	logic [7:0]  addr;
	int          n_checks = 0;
	int          n_mismatch = 0;
	int          n_we = 0;
	logic [7:0]  we_addr;
	hjprc_word_t we_data;
	logic [15:0] rd;
	logic        oe, tdo;

	always #10 clk = ~clk;

	hjprc_top #(.PWRUP_HOLD_CYC(10)) i_hjprc_top
	(
		.sys_clk_i(clk), .rst_i(rst), .port_mode_i(pmode),
		.reset_n_i(rst_n), .shared_serial_clock_i(sclk),
		.shared_serial_in_i(sdi), .shared_select_i(sel),
		.shared_serial_out_o(sdo), .shared_serial_out_oe_o(sdo_oe),
		.lock_select_n_i(lsel_n), .ref_present_i(ref_p),
		.lock_achieved_i(ach), .lock_state_o(lst),
		.audio_follow_video_o(aud), .func_reset_o(fres),
		.signal_pins_oe_o(poe), .video_clk_force_low_o(vlow),
		.cfg_we_o(we), .cfg_wdata_o(wdata), .cfg_addr_o(addr),
		.cfg_rdata_i(rdata)
	);

	hjprc_host_model i_hjprc_host_model
	(
		.sys_clk_i(clk), .shared_serial_out_i(sdo),
		.shared_serial_out_oe_i(sdo_oe), .sclk_o(sclk), .sel_o(sel),
		.sdi_o(sdi)
	);

	// write pulse lasts one cycle; taken mid-cycle, where it is settled
	always @(negedge clk)
		if (we === 1'b1)
		begin
			n_we++;
			we_addr = addr;
			we_data = wdata;
		end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic t_reset_host;
		pmode = 1'b0;
		rst_n = 1'b0;
		cyc(4);
		`CHK("func_reset", 1'b1, fres)
		`CHK("pins_oe", 1'b0, poe)
		`CHK("vclk_low", 1'b1, vlow)
		`CHK("wdata", 16'h0000, wdata)
		rst_n = 1'b1;
		cyc(4);
		`CHK("func_reset", 1'b0, fres)
		`CHK("pins_oe", 1'b1, poe)
		`CHK("vclk_low", 1'b0, vlow)
		$display("test reset_host done");
	endtask : t_reset_host

	task automatic t_host;
		int n0;
		logic [31:0] tbl [2];
		tbl = '{32'h0012a5c3, 32'h00ff5a3c};
		// back-to-back writes, boundary address included
		foreach (tbl[k])
		begin
			n0 = n_we;
			i_hjprc_host_model.frame(tbl[k][31:16], tbl[k][15:0], 1'b0, rd, oe);
			`CHK("we_count", n0 + 1, n_we)
			`CHK("we_addr", tbl[k][23:16], we_addr)
			`CHK("we_data", tbl[k][15:0], we_data)
		end
		n0 = n_we;
		i_hjprc_host_model.frame(16'h0012, 16'hffff, 1'b1, rd, oe);
		`CHK("we_count", n0, n_we)
		rdata = 16'h3c96;
		i_hjprc_host_model.frame(16'h8034, 16'h0000, 1'b0, rd, oe);
		`CHK("rd", 16'h3c96, rd)
		`CHK("sdo_oe", 1'b1, oe)
		`CHK("we_count", n0, n_we)
		cyc(4);
		`CHK("sdo_oe", 1'b0, sdo_oe)
		$display("test host done");
	endtask : t_host

	// test-logic-reset to shift-DR
	task automatic walk;
		i_hjprc_host_model.tck(1'b0, 1'b0, tdo, oe);
		i_hjprc_host_model.tck(1'b1, 1'b0, tdo, oe);
		i_hjprc_host_model.tck(1'b0, 1'b0, tdo, oe);
		i_hjprc_host_model.tck(1'b0, 1'b0, tdo, oe);
	endtask : walk

	task automatic t_test;
		logic [3:0] pat;
		int n0;
		pat = 4'b1011;
		pmode = 1'b1;
		cyc(4);
		repeat (5) i_hjprc_host_model.tck(1'b1, 1'b0, tdo, oe);
		walk;
		`CHK("tdo", 1'b0, tdo)
		`CHK("tdo_oe", 1'b1, oe)
		for (int i = 0; i < 4; i++)
		begin
			i_hjprc_host_model.tck(1'b0, pat[i], tdo, oe);
			`CHK("tdo", pat[i], tdo)
		end
		rst_n = 1'b0;
		cyc(4);
		`CHK("func_reset", 1'b1, fres)
		`CHK("pins_oe", 1'b1, poe)
		i_hjprc_host_model.tck(1'b0, 1'b1, tdo, oe);
		`CHK("tdo_oe", 1'b0, oe)
		rst_n = 1'b1;
		cyc(4);
		walk;
		`CHK("tdo_oe", 1'b1, oe)
		n0 = n_we;
		i_hjprc_host_model.frame(16'h0012, 16'h1234, 1'b0, rd, oe);
		`CHK("we_count", n0, n_we)
		pmode = 1'b0;
		cyc(4);
		$display("test test_port done");
	endtask : t_test

	task automatic t_lock;
		lsel_n = 1'b1;
		cyc(4);
		`CHK("lock", HJPRC_LK_FREE, lst)
		`CHK("audio", 1'b1, aud)
		lsel_n = 1'b0;
		cyc(4);
		`CHK("lock", HJPRC_LK_DEFAULT, lst)
		lsel_n = 1'b1;
		cyc(4);
		ref_p = 1'b1;
		cyc(2);
		lsel_n = 1'b0;
		cyc(8);
		`CHK("lock", HJPRC_LK_ACQUIRE, lst)
		ach = 1'b1;
		cyc(2);
		`CHK("lock", HJPRC_LK_LOCKED, lst)
		`CHK("audio", 1'b1, aud)
		ref_p = 1'b0;
		cyc(2);
		`CHK("lock", HJPRC_LK_DEFAULT, lst)
		lsel_n = 1'b1;
		cyc(4);
		`CHK("lock", HJPRC_LK_FREE, lst)
		$display("test lock done");
	endtask : t_lock

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// whole run is well under 200 us; this limit only catches a hang
	initial
	begin
		#1000000;
		n_mismatch++;
		final_report;
	end

	initial
	begin
		// device reset pin stays low across bench reset and beyond
		cyc(6);
		rst = 1'b0;
		cyc(10);
		t_reset_host;
		t_host;
		t_test;
		t_lock;
		final_report;
	end
endmodule : tb
